// file: design/fftc_engine.sv
`timescale 1ns/1ps
`include "fftc_params.svh"
`default_nettype none

module fftc_engine
   import fftc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   fftc_link_if.engine     link,
   output var  logic       engine_active
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   // Data vector doubles as reordered_destination; separate arrays
   // give each vector its own ports, so one is read while the other is written
   fftc_cplx_t  dbuf [1024];
   fftc_cplx_t  sbuf [1024];
   fftc_q15_t   tw_cos [`FFTC_TWID_COUNT];
   fftc_q15_t   tw_sin [`FFTC_TWID_COUNT];

   fftc_state_t state;
   logic        active;
   logic        done;
   logic        result_sel;
   fftc_op_t    op;
   logic        inv;
   logic        unsc;
   logic [3:0]  len;
   logic [3:0]  stage;
   fftc_idx_t   cnt;

   logic [10:0] n_elems;
   fftc_idx_t   hmask;
   fftc_idx_t   top;
   fftc_idx_t   bot;
   logic [8:0]  tw_idx;
   fftc_idx_t   rev_idx;
   fftc_cplx_t  rd_a;
   fftc_cplx_t  rd_b;
   logic        issue;
   logic        host_wr;

   logic [4:0]  vpipe;
   fftc_idx_t   ta [5];
   fftc_idx_t   tb [5];
   fftc_cplx_t  a1;
   fftc_cplx_t  a2;
   fftc_cplx_t  a3;
   fftc_cplx_t  b1;
   fftc_q15_t   wr1;
   fftc_q15_t   wi1;
   logic signed [32:0] pr2;
   logic signed [32:0] pi2;
   logic signed [17:0] tr3;
   logic signed [17:0] ti3;
   logic signed [18:0] xr4;
   logic signed [18:0] xi4;
   logic signed [18:0] yr4;
   logic signed [18:0] yi4;
   fftc_cplx_t  x5;
   fftc_cplx_t  y5;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Reverse all ten index bits
   function automatic fftc_idx_t rev10(input fftc_idx_t v);
      fftc_idx_t r;
      r = '0;
      for (int i = 0; i < 10; i++) begin
         r[9 - i] = v[i];
      end
      return r;
   endfunction

   // Halve with round-half-up, or wrap when unscaled
   function automatic fftc_q15_t fit(input logic signed [18:0] v,
                                     input logic keep);
      logic signed [18:0] r;
      r = (v + 19'sh0_0001) >>> 1;
      return keep ? v[15:0] : r[15:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Twiddle table, W(k) = cos - j sin of 2*pi*k/1024

   // Computed at elaboration; +1.0 does not fit Q15, so it clamps
   for (genvar k = 0; k < `FFTC_TWID_COUNT; k++) begin : g_tw
      localparam real ANG = 3.14159265358979 * k / 512.0;
      localparam int  CR  = $rtoi($floor($cos(ANG) * `FFTC_Q15_ONE + 0.5));
      localparam int  SR  = $rtoi($floor($sin(ANG) * `FFTC_Q15_ONE + 0.5));
      localparam int  CC  = (CR > `FFTC_Q15_MAX) ? `FFTC_Q15_MAX : CR;
      localparam int  SC  = (SR > `FFTC_Q15_MAX) ? `FFTC_Q15_MAX : SR;
      assign tw_cos[k] = 16'(CC);
      assign tw_sin[k] = 16'(SC);
   end

   ////////////////////////////////////////////////////////////////////////
   // Butterfly addressing

   // Butterfly cnt of stage s: span h = 2^s, twiddle step 1024/(2h)
   always_comb begin
      n_elems = 11'(1) << len;
      hmask   = fftc_idx_t'((11'(1) << stage) - 11'(1));
      top     = ({cnt[8:0], 1'b0} & ~{hmask[8:0], 1'b1}) | (cnt & hmask);
      bot     = top | (hmask + 10'h001);
      tw_idx  = 9'((cnt & hmask) << (4'h9 - stage));
      rev_idx = rev10(cnt) >> (4'ha - len);
      // Even stages read data and fill scratch, odd ones the reverse
      rd_a    = stage[0] ? sbuf[top] : dbuf[top];
      rd_b    = stage[0] ? sbuf[bot] : dbuf[bot];
      issue   = (state == FFTC_ST_ISSUE);
      host_wr = link.mem_req & link.mem_we & (state == FFTC_ST_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state      <= FFTC_ST_IDLE;
         active     <= 1'b0;
         done       <= 1'b0;
         result_sel <= 1'b0;
         op         <= FFTC_OP_TRANSFORM;
         inv        <= 1'b0;
         unsc       <= 1'b0;
         len        <= `FFTC_LOG2_MIN;
         stage      <= 4'h0;
         cnt        <= '0;
      end else begin
         done <= 1'b0;
         unique case (state)
            // Out-of-range lengths are refused like a start when busy
            FFTC_ST_IDLE: begin
               if (link.start && link.len_log2 >= `FFTC_LOG2_MIN &&
                   link.len_log2 <= `FFTC_LOG2_MAX) begin
                  op     <= link.op;
                  inv    <= link.inverse_select_value;
                  unsc   <= link.unscaled_mode;
                  len    <= link.len_log2;
                  stage  <= 4'h0;
                  cnt    <= '0;
                  active <= 1'b1;
                  state  <= (link.op == FFTC_OP_REVERSE) ?
                            FFTC_ST_REVERSE : FFTC_ST_ISSUE;
               end
            end
            // Scratch is the source, data the destination
            FFTC_ST_REVERSE: begin
               cnt <= cnt + 10'h001;
               if (11'(cnt) == n_elems - 11'h001) begin
                  state      <= FFTC_ST_IDLE;
                  active     <= 1'b0;
                  done       <= 1'b1;
                  result_sel <= 1'b0;
               end
            end
            FFTC_ST_ISSUE: begin
               cnt <= cnt + 10'h001;
               if (11'(cnt) == (n_elems >> 1) - 11'h001) begin
                  cnt   <= '0;
                  state <= FFTC_ST_DRAIN;
               end
            end
            // Next pass reads what this one writes, so wait for the pipe
            FFTC_ST_DRAIN: begin
               if (vpipe == 5'h00) begin
                  if (stage == len - 4'h1) begin
                     state      <= FFTC_ST_IDLE;
                     active     <= 1'b0;
                     done       <= 1'b1;
                     result_sel <= len[0];
                  end else begin
                     stage <= stage + 4'h1;
                     state <= FFTC_ST_ISSUE;
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Butterfly pipeline, one butterfly issued per cycle

   // Valid and address tracking; result register valid at vpipe[4]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vpipe <= 5'h00;
      end else begin
         vpipe <= {vpipe[3:0], issue};
      end
   end

   always_ff @(posedge pclk) begin
      ta[0] <= top;
      tb[0] <= bot;
      for (int i = 1; i < `FFTC_LATENCY; i++) begin
         ta[i] <= ta[i - 1];
         tb[i] <= tb[i - 1];
      end
   end

   // Twiddle multiply in two steps, then add and subtract, then scale
   always_ff @(posedge pclk) begin
      a1  <= rd_a;
      b1  <= rd_b;
      wr1 <= tw_cos[tw_idx];
      wi1 <= inv ? tw_sin[tw_idx] : -tw_sin[tw_idx];
      a2  <= a1;
      pr2 <= 33'(b1.re) * 33'(wr1) - 33'(b1.im) * 33'(wi1);
      pi2 <= 33'(b1.re) * 33'(wi1) + 33'(b1.im) * 33'(wr1);
      a3  <= a2;
      tr3 <= 18'((pr2 + 33'sh0_4000) >>> 15);
      ti3 <= 18'((pi2 + 33'sh0_4000) >>> 15);
      xr4 <= 19'(a3.re) + 19'(tr3);
      xi4 <= 19'(a3.im) + 19'(ti3);
      yr4 <= 19'(a3.re) - 19'(tr3);
      yi4 <= 19'(a3.im) - 19'(ti3);
      x5  <= '{re: fit(xr4, unsc), im: fit(xi4, unsc)};
      y5  <= '{re: fit(yr4, unsc), im: fit(yi4, unsc)};
   end

   ////////////////////////////////////////////////////////////////////////
   // Vector memories

   // Writers never overlap: host only when idle, passes never together
   always_ff @(posedge pclk) begin
      if (host_wr && !link.mem_scratch) begin
         dbuf[link.mem_idx] <= link.mem_wdata;
      end
      if (state == FFTC_ST_REVERSE) begin
         dbuf[rev_idx] <= sbuf[cnt];
      end
      if (vpipe[4] && stage[0]) begin
         dbuf[ta[4]] <= x5;
         dbuf[tb[4]] <= y5;
      end
   end

   always_ff @(posedge pclk) begin
      if (host_wr && link.mem_scratch) begin
         sbuf[link.mem_idx] <= link.mem_wdata;
      end
      if (vpipe[4] && !stage[0]) begin
         sbuf[ta[4]] <= x5;
         sbuf[tb[4]] <= y5;
      end
   end

   // Reads always answer next cycle; zero while busy, never a hang
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.mem_rvalid <= 1'b0;
         link.mem_rdata  <= '0;
      end else begin
         link.mem_rvalid <= link.mem_req & ~link.mem_we;
         if (link.mem_req && !link.mem_we) begin
            if (active) begin
               link.mem_rdata <= '0;
            end else if (link.mem_scratch) begin
               link.mem_rdata <= sbuf[link.mem_idx];
            end else begin
               link.mem_rdata <= dbuf[link.mem_idx];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Completion outputs

   assign link.busy       = active;
   assign link.done       = done;
   assign link.result_sel = result_sel;
   assign engine_active   = active;

endmodule

`default_nettype wire

// file: design/fftc_requester.sv
`timescale 1ns/1ps
`include "fftc_params.svh"
`default_nettype none

module fftc_requester
   import fftc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   fftc_link_if.requester   link
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic        acc;
   logic        commit;
   logic        data_rd;
   logic        pend;
   logic        done_flag;
   fftc_idx_t   idx;
   logic        scr;
   logic [31:0] rmux;

   always_comb begin
      acc     = psel & penable & ~pready;
      commit  = psel & penable & pready;
      data_rd = (paddr == `FFTC_REG_DATA) & ~pwrite;
      rmux    = 32'h0000_0000;
      unique case (paddr)
         `FFTC_REG_CTRL: begin
            rmux[`FFTC_CTRL_OP]   = link.op;
            rmux[`FFTC_CTRL_INV]  = link.inverse_select_value;
            rmux[`FFTC_CTRL_UNSC] = link.unscaled_mode;
            rmux[`FFTC_CTRL_LEN_HI:`FFTC_CTRL_LEN_LO] = link.len_log2;
         end
         // Software checks location here before reading results
         `FFTC_REG_STATUS: begin
            rmux[`FFTC_STAT_BUSY] = link.busy;
            rmux[`FFTC_STAT_RSEL] = link.result_sel;
            rmux[`FFTC_STAT_DONE] = done_flag;
         end
         `FFTC_REG_ADDR: begin
            rmux[`FFTC_ADDR_IDX_HI:0] = idx;
            rmux[`FFTC_ADDR_SCR]      = scr;
         end
         default: rmux = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // APB answer and vector memory requests

   // Data reads wait for the engine; all else answers after one wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready           <= 1'b0;
         prdata           <= 32'h0000_0000;
         pslverr          <= 1'b0;
         pend             <= 1'b0;
         link.mem_req     <= 1'b0;
         link.mem_we      <= 1'b0;
         link.mem_scratch <= 1'b0;
         link.mem_idx     <= '0;
         link.mem_wdata   <= '0;
      end else begin
         pready       <= 1'b0;
         link.mem_req <= 1'b0;
         if (acc && data_rd) begin
            if (!pend) begin
               link.mem_req     <= 1'b1;
               link.mem_we      <= 1'b0;
               link.mem_scratch <= scr;
               link.mem_idx     <= idx;
               pend             <= 1'b1;
            end else if (link.mem_rvalid) begin
               pready <= 1'b1;
               prdata <= link.mem_rdata;
               pend   <= 1'b0;
            end
         end else if (acc) begin
            pready <= 1'b1;
            prdata <= rmux;
         end
         if (commit && pwrite && paddr == `FFTC_REG_DATA) begin
            link.mem_req     <= 1'b1;
            link.mem_we      <= 1'b1;
            link.mem_scratch <= scr;
            link.mem_idx     <= idx;
            link.mem_wdata   <= pwdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Element pointer, steps after each data access

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx <= '0;
         scr <= 1'b0;
      end else if (commit && pwrite && paddr == `FFTC_REG_ADDR) begin
         idx <= pwdata[`FFTC_ADDR_IDX_HI:0];
         scr <= pwdata[`FFTC_ADDR_SCR];
      end else if (commit && paddr == `FFTC_REG_DATA) begin
         idx <= idx + 10'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command, settings registered together with the start pulse

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.start                <= 1'b0;
         link.op                   <= FFTC_OP_TRANSFORM;
         link.inverse_select_value <= 1'b0;
         link.unscaled_mode        <= 1'b0;
         link.len_log2             <= `FFTC_LOG2_MIN;
      end else begin
         link.start <= 1'b0;
         if (commit && pwrite && paddr == `FFTC_REG_CTRL) begin
            link.start <= pwdata[`FFTC_CTRL_START];
            link.op    <= fftc_op_t'(pwdata[`FFTC_CTRL_OP]);
            link.inverse_select_value <= pwdata[`FFTC_CTRL_INV];
            link.unscaled_mode        <= pwdata[`FFTC_CTRL_UNSC];
            link.len_log2 <= pwdata[`FFTC_CTRL_LEN_HI:`FFTC_CTRL_LEN_LO];
         end
      end
   end

   // Sticky completion; a done in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_flag <= 1'b0;
      end else if (link.done) begin
         done_flag <= 1'b1;
      end else if (commit && pwrite && paddr == `FFTC_REG_STATUS &&
                   pwdata[`FFTC_STAT_DONE]) begin
         done_flag <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// file: shared/fftc_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface fftc_link_if
   import fftc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn
);
   // Command group
   logic       start;
   fftc_op_t   op;
   logic       inverse_select_value;
   logic       unscaled_mode;
   logic [3:0] len_log2;
   // Completion group
   logic       busy;
   logic       done;
   logic       result_sel;
   // Vector memory access group
   logic       mem_req;
   logic       mem_we;
   logic       mem_scratch;
   fftc_idx_t  mem_idx;
   fftc_cplx_t mem_wdata;
   logic       mem_rvalid;
   fftc_cplx_t mem_rdata;

   modport engine (
      input  pclk, presetn, start, op, inverse_select_value, unscaled_mode,
      input  len_log2, mem_req, mem_we, mem_scratch, mem_idx, mem_wdata,
      output busy, done, result_sel, mem_rvalid, mem_rdata
   );

   modport requester (
      input  pclk, presetn, busy, done, result_sel, mem_rvalid, mem_rdata,
      output start, op, inverse_select_value, unscaled_mode, len_log2,
      output mem_req, mem_we, mem_scratch, mem_idx, mem_wdata
   );
endinterface

`default_nettype wire

// file: shared/fftc_params.svh
`ifndef FFTC_PARAMS_SVH
`define FFTC_PARAMS_SVH

// Transform length limits as log2 of the element count
`define FFTC_LOG2_MIN    4'h3
`define FFTC_LOG2_MAX    4'ha
// Twiddle table entries, cosine and sine of 2*pi*k/1024
`define FFTC_TWID_COUNT  512
// Cycles from operand read to result register, single-stage pass
`define FFTC_LATENCY     5
// Q15 rounding constants
`define FFTC_Q15_ONE     32768.0
`define FFTC_Q15_MAX     32767

// Register byte offsets on the requester's APB port
`define FFTC_REG_CTRL    8'h00
`define FFTC_REG_STATUS  8'h04
`define FFTC_REG_ADDR    8'h08
`define FFTC_REG_DATA    8'h0c

// Control register fields
`define FFTC_CTRL_START  0
`define FFTC_CTRL_OP     1
`define FFTC_CTRL_INV    2
`define FFTC_CTRL_UNSC   3
`define FFTC_CTRL_LEN_LO 4
`define FFTC_CTRL_LEN_HI 7

// Status register fields
`define FFTC_STAT_BUSY   0
`define FFTC_STAT_RSEL   1
`define FFTC_STAT_DONE   2

// Address register fields
`define FFTC_ADDR_IDX_HI 9
`define FFTC_ADDR_SCR    16

`endif

// file: shared/fftc_pkg.sv
package fftc_pkg;

   // One signed_q15_format component: sign bit plus fifteen fraction bits
   typedef logic signed [15:0] fftc_q15_t;

   // Complex element: real in the upper half, imaginary in the lower
   typedef struct packed {
      logic signed [15:0] re;
      logic signed [15:0] im;
   } fftc_cplx_t;

   typedef logic [9:0] fftc_idx_t;

   // Operation carried by a start request
   typedef enum logic {
      FFTC_OP_TRANSFORM,
      FFTC_OP_REVERSE
   } fftc_op_t;

   // Engine sequencer
   typedef enum logic [1:0] {
      FFTC_ST_IDLE,
      FFTC_ST_REVERSE,
      FFTC_ST_ISSUE,
      FFTC_ST_DRAIN
   } fftc_state_t;

endpackage

// file: sim/fftc_link_chk.sv
`timescale 1ns/1ps
`default_nettype none

module fftc_link_chk
   import fftc_pkg::*;
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       start,
   input wire fftc_op_t   op,
   input wire logic [3:0] len_log2,
   input wire logic       busy,
   input wire logic       done,
   input wire logic       result_sel,
   input wire logic       mem_req,
   input wire logic       mem_we,
   input wire logic       mem_rvalid
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic     len_ok;
   logic     taken;
   logic     last_len0;
   fftc_op_t last_op;

   // A start only counts when idle and the length is legal
   assign len_ok = (len_log2 >= 4'h3) && (len_log2 <= 4'ha);
   assign taken  = start && !busy && len_ok;

   // Remember the accepted command, done is judged against it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_len0 <= 1'b0;
         last_op   <= FFTC_OP_TRANSFORM;
      end else if (taken) begin
         last_len0 <= len_log2[0];
         last_op   <= op;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   chk_start_taken: assert property (taken |=> busy)
      else $error("accepted start did not raise busy");
   chk_bad_len: assert property (
      start && !busy && !len_ok |=> !busy)
      else $error("start with illegal length was obeyed");
   chk_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");
   chk_done_ends_busy: assert property (done |-> $fell(busy))
      else $error("done not together with busy falling");
   chk_rev_timing: assert property (
      taken && op == FFTC_OP_REVERSE && len_log2 == 4'h3 |=>
      busy[*8] ##1 (done && !busy && !result_sel))
      else $error("eight element copy timing or location wrong");
   chk_rsel_hold: assert property ($changed(result_sel) |-> done)
      else $error("result location moved without done");
   chk_rsel_parity: assert property (
      done && last_op == FFTC_OP_TRANSFORM |-> result_sel == last_len0)
      else $error("result location does not match stage count");
   chk_mem_answer: assert property (
      mem_req && !mem_we && !busy |=> mem_rvalid)
      else $error("element read not answered next cycle");

   // Main scenarios
   cover property (taken && op == FFTC_OP_REVERSE);
   cover property (done && result_sel);
   cover property (done && !result_sel && last_op == FFTC_OP_TRANSFORM);
endmodule

`default_nettype wire

// file: sim/test_fft_coprocessor_bitreverse.sv
`timescale 1ns/1ps
`include "fftc_params.svh"
`default_nettype none

module test_fft_coprocessor_bitreverse
   import fftc_pkg::*;
;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        active;
   logic [31:0] rv;
   logic [31:0] vec [0:15];
   logic [31:0] res [0:15];
   int          fails;
   int          checks_done;
   int          cyc;

   fftc_link_if link (.pclk(pclk), .presetn(presetn));
   fftc_engine u_fftc_engine (.pclk(pclk), .presetn(presetn),
      .link(link.engine), .engine_active(active));
   fftc_requester u_fftc_requester (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link.requester));
   fftc_link_chk u_fftc_link_chk (.pclk(pclk), .presetn(presetn),
      .start(link.start), .op(link.op), .len_log2(link.len_log2),
      .busy(link.busy), .done(link.done), .result_sel(link.result_sel),
      .mem_req(link.mem_req), .mem_we(link.mem_we),
      .mem_rvalid(link.mem_rvalid));

   // 40 MHz
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One APB transfer; idle edge first so strobes never toggle twice
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the cycle ceiling ends a wait that never answers
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Poll for done, compare status, then clear the sticky flag
   task automatic wait_done(input logic [31:0] exp);
      int n;
      n = 0;
      do begin
         apb(1'b0, `FFTC_REG_STATUS, 32'h0);
         n++;
      end while (rv[2] !== 1'b1 && n < 100);
      check("status", rv, exp);
      apb(1'b1, `FFTC_REG_STATUS, 32'h0000_0004);
   endtask

   task automatic load(input logic scr, input int n);
      apb(1'b1, `FFTC_REG_ADDR, {15'h0, scr, 16'h0});
      for (int i = 0; i < n; i++) apb(1'b1, `FFTC_REG_DATA, vec[i]);
   endtask

   task automatic fetch(input logic scr, input int n);
      apb(1'b1, `FFTC_REG_ADDR, {15'h0, scr, 16'h0});
      for (int i = 0; i < n; i++) begin
         apb(1'b0, `FFTC_REG_DATA, 32'h0);
         res[i] = rv;
      end
   endtask

   // Impulse transform; result read from scratch for odd lengths, data for even
   task automatic fft(input logic [3:0] l, input logic inv,
                      input logic unsc, input int pos, input logic [31:0] x);
      for (int i = 0; i < 16; i++) vec[i] = (i == pos) ? x : 32'h0;
      load(1'b0, 1 << l);
      apb(1'b1, `FFTC_REG_CTRL, {24'h0, l, unsc, inv, 2'b01});
      wait_done({29'h0, 1'b1, l[0], 1'b0});
      fetch(l[0], 1 << l);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_idle;
      apb(1'b0, `FFTC_REG_STATUS, 32'h0);
      check("idle status", rv, 32'h0);
      apb(1'b1, 8'h10, 32'hffff_ffff);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped", rv, 32'h0);
      check("slave error", {31'h0, pslverr}, 32'h0);
      $display("test idle done");
   endtask

   task automatic t_reverse;
      for (int i = 0; i < 8; i++) vec[i] = i * 32'h0102_0301 + 32'h8000_7fff;
      load(1'b1, 8);
      apb(1'b1, `FFTC_REG_CTRL, 32'h0000_0033);
      // Second start lands mid-copy and must be dropped
      apb(1'b1, `FFTC_REG_CTRL, 32'h0000_0031);
      check("active", {31'h0, active}, 32'h1);
      wait_done(32'h0000_0004);
      fetch(1'b0, 8);
      for (int j = 0; j < 8; j++) begin
         check("reordered", res[{j[0], j[1], j[2]}], vec[j]);
      end
      $display("test reverse done");
   endtask

   task automatic t_bad_len;
      apb(1'b1, `FFTC_REG_CTRL, 32'h0000_0021);
      apb(1'b0, `FFTC_REG_STATUS, 32'h0);
      check("short length", rv, 32'h0);
      apb(1'b1, `FFTC_REG_CTRL, 32'h0000_00b1);
      apb(1'b0, `FFTC_REG_STATUS, 32'h0);
      check("long length", rv, 32'h0);
      $display("test bad length done");
   endtask

   // Halving per stage: odd length ends in scratch, even in data
   task automatic t_scaled;
      fft(4'h3, 1'b0, 1'b0, 0, 32'h4000_2000);
      for (int i = 0; i < 8; i++) begin
         check("scaled 8", res[i], 32'h0800_0400);
      end
      fft(4'h4, 1'b0, 1'b0, 0, 32'h4000_2000);
      for (int i = 0; i < 16; i++) begin
         check("scaled 16", res[i], 32'h0400_0200);
      end
      $display("test scaled done");
   endtask

   // Natural index 1 sits at reversed slot 4; quarter bins are exact
   task automatic t_direction;
      for (int v = 0; v < 2; v++) begin
         fft(4'h3, v[0], 1'b1, 4, 32'h2000_0000);
         check("bin 0", res[0], 32'h2000_0000);
         check("bin 2", res[2], v ? 32'h0000_2000 : 32'h0000_e000);
         check("bin 4", res[4], 32'he000_0000);
         check("bin 6", res[6], v ? 32'h0000_e000 : 32'h0000_2000);
      end
      $display("test direction done");
   endtask

   // Hang guard, far above the several hundred cycles needed
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         summarize();
      end
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_idle();
      t_reverse();
      t_bad_len();
      t_scaled();
      t_direction();
      summarize();
   end
endmodule

`default_nettype wire
